// >>> core/tv_scaler_pkg.sv
`default_nettype none

package tv_scaler_pkg;

	// ==========================================================================
	// Register indices
	// ==========================================================================
	localparam logic [7:0] IDX_REVISION_LOW = 8'h25;
	localparam logic [7:0] IDX_ATTR_INDEX_READBACK = 8'h26;
	localparam logic [7:0] IDX_DEVICE_IDENTITY = 8'h27;
	localparam logic [7:0] IDX_TV_OUT_CONTROL = 8'h30;
	localparam logic [7:0] IDX_HORIZ_COEF_HIGH = 8'h31;
	localparam logic [7:0] IDX_VERT_COEF_HIGH = 8'h32;
	localparam logic [7:0] IDX_COEF_LOW_NIBBLES = 8'h39;

	// ==========================================================================
	// Field positions and reset values
	// ==========================================================================
	localparam int TV_MODE_BIT = 6;
	localparam int TV_POWER_BIT = 3;
	localparam int NTSC_PAL_BIT = 2;
	localparam int HT_DELAY_LSB = 4;
	localparam int CSYNC_DELAY_LSB = 0;
	localparam int VIDEO_SRC_BIT = 5;
	localparam logic [7:0] TV_CTRL_WMASK = 8'h7F;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [11:0] COEF_RESET = 12'h000;
	localparam logic [11:0] COEF_MIN = 12'h400;
	localparam logic [12:0] COEF_UNITY = 13'h1000;
	localparam int DELAY_DEPTH = 6;
	// Arbitrary neutral identity and revision values.
	localparam logic [5:0] DEVICE_ID_CODE = 6'h2A;
	localparam logic [9:0] REVISION_CODE = 10'h001;

	// ==========================================================================
	// Carriers
	// ==========================================================================
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] index;
		logic [7:0] wrData;
	} reg_req_t;

	typedef struct packed {
		logic tvPower;
		logic ntscSel;
		logic tvMode;
		logic [1:0] htDelay;
		logic [1:0] csyncDelay;
	} tv_ctrl_t;

	typedef struct packed {
		logic [11:0] horizCoef;
		logic [11:0] vertCoef;
		logic horizUnity;
		logic vertUnity;
		logic horizValid;
		logic vertValid;
	} scale_cfg_t;

endpackage : tv_scaler_pkg
`default_nettype wire

// >>> core/dot_delay_line.sv
`timescale 1ns/1ps
`default_nettype none

module dot_delay_line
	import tv_scaler_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Signal path
	input wire logic dotEn,
	input wire logic [1:0] sel,
	input wire logic din,
	output logic dout
);

	logic [DELAY_DEPTH-1:0] tap_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tap_r <= '0;
		end else if (dotEn) begin
			tap_r <= {tap_r[DELAY_DEPTH-2:0], din};
		end
	end

	// Code 0 passes straight through; codes 1..3 take taps 2, 4 and 6.
	always_comb begin
		case (sel)
			2'd0: dout = din;
			2'd1: dout = tap_r[1];
			2'd2: dout = tap_r[3];
			2'd3: dout = tap_r[5];
			default: dout = din;
		endcase
	end

endmodule : dot_delay_line
`default_nettype wire

// >>> core/crtc_ext_tv_scaler_regs.sv
`timescale 1ns/1ps
`default_nettype none

module crtc_ext_tv_scaler_regs
	import tv_scaler_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Indexed register port
	input wire reg_req_t regReq,
	output logic [7:0] rdData,
	// Attribute controller state
	input wire logic [5:0] attrIndex,
	// Sequencer pin levels and pin outputs
	input wire logic [2:0] seqPinLevels,
	output logic progPinZero,
	output logic progPinOne,
	output logic progPinTwo,
	// Timing sources, one enable per dot clock
	input wire logic dotEn,
	input wire logic horizTotalIn,
	input wire logic csyncIn,
	output logic horizTotalOut,
	output logic csyncOutN,
	output logic palTiming,
	// Scaler configuration
	output scale_cfg_t scaleCfg
);

	// ==========================================================================
	// Register storage
	// ==========================================================================
	logic [7:0] tvCtrl_r;
	logic [7:0] horizHigh_r;
	logic [7:0] vertHigh_r;
	logic [7:0] lowNib_r;
	tv_ctrl_t tv;
	logic [11:0] horizCoef;
	logic [11:0] vertCoef;
	logic rawHt;
	logic rawCsync;

	// Reserved bit 7 of TV control never stores.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tvCtrl_r <= RESET_BYTE;
		end else if (regReq.wrEn && regReq.index == IDX_TV_OUT_CONTROL) begin
			tvCtrl_r <= regReq.wrData & TV_CTRL_WMASK;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			horizHigh_r <= RESET_BYTE;
		end else if (regReq.wrEn && regReq.index == IDX_HORIZ_COEF_HIGH) begin
			horizHigh_r <= regReq.wrData;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vertHigh_r <= RESET_BYTE;
		end else if (regReq.wrEn && regReq.index == IDX_VERT_COEF_HIGH) begin
			vertHigh_r <= regReq.wrData;
		end
	end

	// The shared nibble register lives elsewhere in the map but both coefficients need it.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lowNib_r <= RESET_BYTE;
		end else if (regReq.wrEn && regReq.index == IDX_COEF_LOW_NIBBLES) begin
			lowNib_r <= regReq.wrData;
		end
	end

	// ==========================================================================
	// Read mux
	// ==========================================================================
	// Revision and identity readback; writes to these indices land nowhere.
	always_comb begin
		case (regReq.index)
			IDX_REVISION_LOW: rdData = REVISION_CODE[7:0];
			IDX_ATTR_INDEX_READBACK: rdData = {2'b00, attrIndex};
			// Fixed identity code above the revision top bits.
			IDX_DEVICE_IDENTITY: rdData = {DEVICE_ID_CODE, REVISION_CODE[9:8]};
			IDX_TV_OUT_CONTROL: rdData = tvCtrl_r;
			IDX_HORIZ_COEF_HIGH: rdData = horizHigh_r;
			IDX_VERT_COEF_HIGH: rdData = vertHigh_r;
			IDX_COEF_LOW_NIBBLES: rdData = lowNib_r;
			default: rdData = RESET_BYTE;
		endcase
	end

	// ==========================================================================
	// TV-out pin control
	// ==========================================================================
	assign tv.tvPower = tvCtrl_r[TV_POWER_BIT];
	assign tv.ntscSel = tvCtrl_r[NTSC_PAL_BIT];
	assign tv.tvMode = tvCtrl_r[TV_MODE_BIT];
	assign tv.htDelay = tvCtrl_r[HT_DELAY_LSB +: 2];
	assign tv.csyncDelay = tvCtrl_r[CSYNC_DELAY_LSB +: 2];

	// Pins 0 and 2 are taken over in TV mode; pin 1 always follows the sequencer.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			progPinZero <= 1'b0;
			progPinOne <= 1'b0;
			progPinTwo <= 1'b0;
		end else if (tv.tvMode) begin
			progPinZero <= tv.tvPower;
			progPinOne <= seqPinLevels[1];
			// Select level drives pin two directly.
			progPinTwo <= tv.ntscSel;
		end else begin
			// Sequencer bits 7:5 map to pins two, one, zero.
			progPinZero <= seqPinLevels[0];
			progPinOne <= seqPinLevels[1];
			progPinTwo <= seqPinLevels[2];
		end
	end

	// PAL timing only meaningful with TV mode; reads low otherwise.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			palTiming <= 1'b0;
		end else begin
			palTiming <= tv.tvMode && !tv.ntscSel;
		end
	end

	// ==========================================================================
	// Dot-clock delays
	// ==========================================================================
	// Horizontal total delay line.
	dot_delay_line htDelayLine (
		.clk(clk),
		.nrst(nrst),
		.dotEn(dotEn),
		.sel(tv.htDelay),
		.din(horizTotalIn),
		.dout(rawHt)
	);

	dot_delay_line csyncDelayLine (
		.clk(clk),
		.nrst(nrst),
		.dotEn(dotEn),
		.sel(tv.csyncDelay),
		.din(csyncIn),
		.dout(rawCsync)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			horizTotalOut <= 1'b0;
		end else begin
			horizTotalOut <= rawHt;
		end
	end

	// Composite sync is held inactive high unless TV mode is on.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			csyncOutN <= 1'b1;
		end else begin
			csyncOutN <= tv.tvMode ? !rawCsync : 1'b1;
		end
	end

	// ==========================================================================
	// Scaler configuration
	// ==========================================================================
	// Horizontal and vertical coefficient assembly.
	assign horizCoef = {horizHigh_r, lowNib_r[7:4]};
	assign vertCoef = {vertHigh_r, lowNib_r[3:0]};

	// The datapath interpolates pixels (horizontal) and repeats lines (vertical);
	// flags here tell it which coefficients are unity or out of range.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scaleCfg <= '{COEF_RESET, COEF_RESET, 1'b1, 1'b1, 1'b1, 1'b1};
		end else begin
			scaleCfg.horizCoef <= horizCoef;
			scaleCfg.vertCoef <= vertCoef;
			scaleCfg.horizUnity <= horizCoef == COEF_RESET;
			scaleCfg.vertUnity <= vertCoef == COEF_RESET;
			// Legal range 1024..4095, plus the zero exception.
			scaleCfg.horizValid <= horizCoef == COEF_RESET || horizCoef >= COEF_MIN;
			// Vertical legal range gates line repetition.
			scaleCfg.vertValid <= vertCoef == COEF_RESET || vertCoef >= COEF_MIN;
		end
	end

	// ==========================================================================
	// Checks
	// ==========================================================================
	identity_fixed_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.index == IDX_DEVICE_IDENTITY |-> rdData[7:2] == DEVICE_ID_CODE)
		else $error("identity code changed");

	revision_split_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.index == IDX_REVISION_LOW |-> rdData == REVISION_CODE[7:0])
		else $error("revision low wrong");

	attr_echo_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.index == IDX_ATTR_INDEX_READBACK |-> rdData == {2'b00, attrIndex})
		else $error("attribute readback wrong");

	tv_pin_zero_a: assert property (
		@(posedge clk) disable iff (!nrst)
		tv.tvMode && $stable(tvCtrl_r) |=> progPinZero == $past(tv.tvPower))
		else $error("tv power pin wrong");

	pin_follow_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!tv.tvMode |=> progPinTwo == $past(seqPinLevels[2]) && csyncOutN)
		else $error("pins not following sequencer");

	ntsc_pin_a: assert property (
		@(posedge clk) disable iff (!nrst)
		tv.tvMode |=> progPinTwo == $past(tv.ntscSel) && palTiming == !$past(tv.ntscSel))
		else $error("ntsc pal select wrong");

	ht_passthru_a: assert property (
		@(posedge clk) disable iff (!nrst)
		tv.htDelay == 2'd0 |=> horizTotalOut == $past(horizTotalIn))
		else $error("undelayed horizontal total wrong");

	horiz_unity_a: assert property (
		@(posedge clk) disable iff (!nrst)
		horizCoef == COEF_RESET |=> scaleCfg.horizUnity && scaleCfg.horizValid)
		else $error("zero coefficient not unity");

	ro_write_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.wrEn && regReq.index == IDX_TV_OUT_CONTROL |=> !tvCtrl_r[7])
		else $error("reserved bit stored");

	video_src_echo_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.index == IDX_ATTR_INDEX_READBACK |->
			rdData[VIDEO_SRC_BIT] == attrIndex[VIDEO_SRC_BIT])
		else $error("video source readback wrong");

	attr_reserved_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.index == IDX_ATTR_INDEX_READBACK |-> rdData[7:6] == 2'b00)
		else $error("attribute reserved bits set");

	revision_top_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.index == IDX_DEVICE_IDENTITY |-> rdData[1:0] == REVISION_CODE[9:8])
		else $error("revision top bits wrong");

	pin_one_follow_a: assert property (
		@(posedge clk) disable iff (!nrst)
		tv.tvMode |=> progPinOne == $past(seqPinLevels[1]))
		else $error("pin one not following sequencer");

	pin_zero_seq_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!tv.tvMode |=> progPinZero == $past(seqPinLevels[0]) &&
			progPinOne == $past(seqPinLevels[1]))
		else $error("pins zero and one not following sequencer");

	pal_off_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!tv.tvMode |=> !palTiming)
		else $error("pal timing without tv mode");

	csync_pass_a: assert property (
		@(posedge clk) disable iff (!nrst)
		tv.tvMode && tv.csyncDelay == 2'd0 |=> csyncOutN == !$past(csyncIn))
		else $error("undelayed composite sync wrong");

	horiz_coef_a: assert property (
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> scaleCfg.horizCoef == {$past(horizHigh_r), $past(lowNib_r[7:4])})
		else $error("horizontal coefficient assembly wrong");

	vert_coef_a: assert property (
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> scaleCfg.vertCoef == {$past(vertHigh_r), $past(lowNib_r[3:0])})
		else $error("vertical coefficient assembly wrong");

	vert_unity_a: assert property (
		@(posedge clk) disable iff (!nrst)
		vertCoef == COEF_RESET |=> scaleCfg.vertUnity && scaleCfg.vertValid)
		else $error("zero vertical coefficient not unity");

	horiz_range_a: assert property (
		@(posedge clk) disable iff (!nrst)
		horizCoef != COEF_RESET && horizCoef < COEF_MIN |=>
			!scaleCfg.horizValid && !scaleCfg.horizUnity)
		else $error("illegal horizontal coefficient accepted");

	vert_range_a: assert property (
		@(posedge clk) disable iff (!nrst)
		vertCoef != COEF_RESET && vertCoef < COEF_MIN |=>
			!scaleCfg.vertValid && !scaleCfg.vertUnity)
		else $error("illegal vertical coefficient accepted");

	horiz_legal_a: assert property (
		@(posedge clk) disable iff (!nrst)
		horizCoef >= COEF_MIN |=> scaleCfg.horizValid && !scaleCfg.horizUnity)
		else $error("legal horizontal coefficient refused");

	vert_legal_a: assert property (
		@(posedge clk) disable iff (!nrst)
		vertCoef >= COEF_MIN |=> scaleCfg.vertValid && !scaleCfg.vertUnity)
		else $error("legal vertical coefficient refused");

	tv_ctrl_store_a: assert property (
		@(posedge clk) disable iff (!nrst)
		regReq.wrEn && regReq.index == IDX_TV_OUT_CONTROL |=>
			tvCtrl_r == ($past(regReq.wrData) & TV_CTRL_WMASK))
		else $error("tv control write not stored");

	ht_two_dot_a: assert property (
		@(posedge clk) disable iff (!nrst)
		tv.htDelay == 2'd1 && $past(dotEn) && $past(dotEn, 2) |=>
			horizTotalOut == $past(horizTotalIn, 3))
		else $error("two dot horizontal total delay wrong");

endmodule : crtc_ext_tv_scaler_regs
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
	import tv_scaler_pkg::*;
;
	typedef struct {
		int kind;
		string name;
		logic [27:0] exp;
	} note_t;

	logic clk;
	logic nrst;
	reg_req_t regReq;
	logic [7:0] rdData;
	logic [5:0] attrIndex;
	logic [2:0] seqPinLevels;
	logic progPinZero, progPinOne, progPinTwo;
	logic dotEn, horizTotalIn, csyncIn;
	logic horizTotalOut, csyncOutN, palTiming;
	scale_cfg_t scaleCfg;
	note_t notes[$];
	event sampleEv;
	int failures = 0;
	int nTests = 0;
	logic [27:0] latH, latC;

	crtc_ext_tv_scaler_regs crtc_ext_tv_scaler_regs_i (.clk(clk), .nrst(nrst), .regReq(regReq),
		.rdData(rdData), .attrIndex(attrIndex), .seqPinLevels(seqPinLevels),
		.progPinZero(progPinZero), .progPinOne(progPinOne), .progPinTwo(progPinTwo),
		.dotEn(dotEn), .horizTotalIn(horizTotalIn), .csyncIn(csyncIn),
		.horizTotalOut(horizTotalOut), .csyncOutN(csyncOutN), .palTiming(palTiming),
		.scaleCfg(scaleCfg));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================================
	// Compare and report
	// ==========================================================================
	task automatic cmpVal(input string name, input logic [27:0] exp, input logic [27:0] got);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : cmpVal

	task automatic cmpCfg(input string name, input scale_cfg_t exp, input scale_cfg_t got);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : cmpCfg

	task automatic end_sim();
		$display("checks %0d failures %0d", nTests, failures);
		if (failures == 0 && nTests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	// The watcher samples at the falling edge, so registered outputs have settled.
	initial begin
		note_t n;
		forever begin
			@(sampleEv);
			n = notes.pop_front();
			case (n.kind)
				0: cmpVal(n.name, n.exp, {20'h0_0000, rdData});
				1: cmpVal(n.name, n.exp,
					{23'h00_0000, progPinZero, progPinOne, progPinTwo, csyncOutN, palTiming});
				2: cmpCfg(n.name, scale_cfg_t'(n.exp), scaleCfg);
				3: cmpVal(n.name, n.exp, latH);
				default: cmpVal(n.name, n.exp, latC);
			endcase
		end
	end

	// ==========================================================================
	// Drivers
	// ==========================================================================
	task automatic check(input int kind, input string name, input logic [27:0] exp);
		note_t n;
		n.kind = kind;
		n.name = name;
		n.exp = exp;
		notes.push_back(n);
		@(negedge clk);
		->sampleEv;
	endtask : check

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		regReq <= '{wrEn: 1'b1, rdEn: 1'b0, index: idx, wrData: d};
		@(posedge clk);
		regReq.wrEn <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] idx, input string name, input logic [7:0] exp);
		@(posedge clk);
		regReq <= '{wrEn: 1'b0, rdEn: 1'b1, index: idx, wrData: 8'h00};
		check(0, name, {20'h0_0000, exp});
	endtask : rd

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	initial begin
		logic [7:0] tv;
		logic [4:0] ep;
		logic [11:0] hc, vc;
		logic [11:0] tbl[6];
		scale_cfg_t ec;
		int k, j;
		nrst = 1'b0;
		regReq = '0;
		attrIndex = '0;
		seqPinLevels = '0;
		dotEn = 1'b0;
		horizTotalIn = 1'b0;
		csyncIn = 1'b0;
		void'($urandom(32'h25c4_56b3));
		tbl = '{12'h000, 12'h3FF, 12'h400, 12'h800, 12'hFFF, 12'(1024 + $urandom_range(3071))};
		repeat (11) @(posedge clk);
		check(2, "scaleCfg reset", {24'h00_0000, 4'hF});
		@(posedge clk);
		nrst <= 1'b1;
		rd(IDX_TV_OUT_CONTROL, "tvCtrl reset", 8'h00);
		rd(IDX_HORIZ_COEF_HIGH, "horizHigh reset", 8'h00);
		rd(IDX_VERT_COEF_HIGH, "vertHigh reset", 8'h00);
		rd(IDX_REVISION_LOW, "revisionLow", REVISION_CODE[7:0]);
		wr(IDX_DEVICE_IDENTITY, 8'hFF);
		wr(IDX_ATTR_INDEX_READBACK, 8'hFF);
		wr(8'h40, 8'h5A);
		rd(IDX_DEVICE_IDENTITY, "identity", {DEVICE_ID_CODE, REVISION_CODE[9:8]});
		rd(8'h40, "unmapped", 8'h00);
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			attrIndex <= 6'($urandom);
			seqPinLevels <= 3'($urandom);
			tv = (8'($urandom) & 8'hBF) | (k[0] ? 8'h40 : 8'h00);
			wr(IDX_TV_OUT_CONTROL, tv);
			ep = tv[6] ? {tv[3], seqPinLevels[1], tv[2], 1'b1, ~tv[2]}
				: {seqPinLevels[0], seqPinLevels[1], seqPinLevels[2], 1'b1, 1'b0};
			rd(IDX_ATTR_INDEX_READBACK, "attrReadback", {2'b00, attrIndex});
			rd(IDX_TV_OUT_CONTROL, "tvCtrl", tv & TV_CTRL_WMASK);
			check(1, "pins", {23'h00_0000, ep});
		end
		for (k = 0; k < 6; k++) begin
			hc = tbl[k];
			vc = tbl[5 - k];
			wr(IDX_HORIZ_COEF_HIGH, hc[11:4]);
			wr(IDX_VERT_COEF_HIGH, vc[11:4]);
			wr(IDX_COEF_LOW_NIBBLES, {hc[3:0], vc[3:0]});
			rd(IDX_VERT_COEF_HIGH, "vertHigh", vc[11:4]);
			rd(IDX_HORIZ_COEF_HIGH, "horizHigh", hc[11:4]);
			rd(IDX_COEF_LOW_NIBBLES, "lowNibbles", {hc[3:0], vc[3:0]});
			ec = '{hc, vc, hc == 0, vc == 0, hc == 0 || hc >= COEF_MIN, vc == 0 || vc >= COEF_MIN};
			check(2, "scaleCfg", ec);
		end
		// A second reset in mid-run must clear every stored coefficient.
		@(posedge clk);
		nrst <= 1'b0;
		check(2, "scaleCfg midrun reset", {24'h00_0000, 4'hF});
		@(posedge clk);
		nrst <= 1'b1;
		rd(IDX_HORIZ_COEF_HIGH, "horizHigh midrun reset", 8'h00);
		@(posedge clk);
		dotEn <= 1'b1;
		for (k = 0; k < 4; k++) begin
			wr(IDX_TV_OUT_CONTROL, 8'h40 | 8'(k << 4) | 8'(k));
			repeat (16) @(posedge clk);
			horizTotalIn <= 1'b1;
			csyncIn <= 1'b1;
			@(posedge clk);
			horizTotalIn <= 1'b0;
			csyncIn <= 1'b0;
			latH = '0;
			latC = '0;
			// Bounded watch; a pulse that never shows leaves the count at zero.
			for (j = 1; j < 20; j++) begin
				#1;
				if (horizTotalOut === 1'b1 && latH == 0) latH = 28'(j);
				if (csyncOutN === 1'b0 && latC == 0) latC = 28'(j);
				@(posedge clk);
			end
			check(3, "htDelay", 28'(2 * k + 1));
			check(4, "csyncDelay", 28'(2 * k + 1));
		end
		repeat (2) @(posedge clk);
		end_sim();
	end

endmodule : testbench

`default_nettype wire
